// [include/bsr_pkg.sv]
// types shared by the bank-one special register map
// assumes: compiled before the interface and the design modules
package bsr_pkg;
    typedef logic [8:0] bsr_addr_t;
    typedef logic [7:0] bsr_byte_t;
    typedef enum logic [1:0] {BSR_RST_NONE, BSR_RST_PWR, BSR_RST_OTHER} bsr_rst_kind_t;
endpackage

// [include/bsr_regs.svh]
// constants of the bank-one special register map: indices, masks, reset values
// assumes: included by bare name from the register map module only
`ifndef BSR_REGS_SVH
`define BSR_REGS_SVH

// ****************************************************************
// register indices (byte address on apb is four times the index)
// ****************************************************************
`define BSR_IDX_IND_DATA   9'h080
`define BSR_IDX_TMR_OPT    9'h081
`define BSR_IDX_PC_LOW     9'h082
`define BSR_IDX_STATUS     9'h083
`define BSR_IDX_IND_PTR    9'h084
`define BSR_IDX_PA_DIR     9'h085
`define BSR_IDX_PB_DIR     9'h086
`define BSR_IDX_PC_DIR     9'h087
`define BSR_IDX_PD_DIR     9'h088
`define BSR_IDX_PE_CTRL    9'h089
`define BSR_IDX_PC_HLATCH  9'h08a
`define BSR_IDX_INT_CTRL   9'h08b
`define BSR_IDX_PIE_A      9'h08c
`define BSR_IDX_PIE_B      9'h08d
`define BSR_IDX_RST_CAUSE  9'h08e
`define BSR_IDX_SSP_CTRL_B 9'h091
`define BSR_IDX_TMR2_PER   9'h092
`define BSR_IDX_SSP_ADDR   9'h093
`define BSR_IDX_SSP_STATE  9'h094
`define BSR_IDX_UTX_CTRL   9'h098
`define BSR_IDX_BAUD_DIV   9'h099
`define BSR_IDX_ADC_RES_LO 9'h09e
`define BSR_IDX_ADC_CFG    9'h09f

// ****************************************************************
// bank and field layout
// ****************************************************************
`define BSR_BANK_ONE       2'h1
`define BSR_ST_IRP         7
`define BSR_ST_BANK_HI     6
`define BSR_ST_BANK_LO     5
`define BSR_ST_TO          4
`define BSR_ST_PD          3
`define BSR_ST_SW_MASK     8'he7
`define BSR_PIE_B_MASK     8'h59
`define BSR_UTX_MASK       8'hf5
`define BSR_ADC_CFG_MASK   8'h8f
`define BSR_PE_DIR_MASK    8'h17

// ****************************************************************
// reset values (power-on / brown-out column)
// ****************************************************************
`define BSR_RST_ZERO       8'h00
`define BSR_RST_ONES       8'hff
`define BSR_RST_PA_DIR     8'h3f
`define BSR_RST_PE_CTRL    8'h07
`define BSR_RST_STATUS     8'h18
`define BSR_KEEP_NONE      8'h00
`define BSR_KEEP_ALL       8'hff
`define BSR_KEEP_INT_CTRL  8'h01

`endif

// [include/bsr_wr_if.sv]
// carrier for write strobe, write data and reset kind inside the map
// assumes: one driver per modport group, all on clk_sys
`timescale 1ns/1ps
interface bsr_wr_if;
    logic       wr_go;
    logic [7:0] wdata;
    logic       rst_pwr;
    logic       rst_oth;
    modport kind (output rst_pwr, rst_oth);
    modport src  (output wr_go, wdata, input rst_pwr, rst_oth);
    modport dst  (input wr_go, wdata, rst_pwr, rst_oth);
endinterface

// [logic/bsr_dreg.sv]
// one storage register with per-bit write mask and two reset columns
// assumes: the carrier gives reset kind and write data on clk_sys
`timescale 1ns/1ps
module bsr_dreg
    import bsr_pkg::*;
#(
    parameter int         W       = 8,
    parameter logic [7:0] PWR_VAL = 8'h00,
    parameter logic [7:0] MASK    = 8'hff,
    parameter logic [7:0] KEEP    = 8'h00
)
(
    input  wire logic         clk_sys,
    bsr_wr_if.dst             bus,
    input  wire logic         sel,
    output logic [W-1:0]      q
);
    // power-up loads column one, other resets keep the KEEP bits
    always_ff @(posedge clk_sys)
    begin
        if (bus.rst_pwr)
            q <= PWR_VAL[W-1:0];
        else if (bus.rst_oth)
            q <= (q & KEEP[W-1:0]) | (PWR_VAL[W-1:0] & ~KEEP[W-1:0]);
        else if (sel && bus.wr_go)
            q <= (bus.wdata[W-1:0] & MASK[W-1:0]) | (q & ~MASK[W-1:0]);
    end
endmodule // bsr_dreg

// [logic/bsr_reg_map.sv]
// bank-one special register map behind an apb slave
// assumes: apb master on clk_sys, core supplies pc low byte and peripheral status
//
// Functional notes
// - unmapped addresses read zero, writes ignored
// - upper pc only via five-bit latch transfer
// - core registers decode identically in every bank
// - pin or watchdog reset loads second column
// - each register takes its tabulated reset value
// - small package: port d/e direction absent, reads zero
// - power-up reset sets direction registers to inputs
`timescale 1ns/1ps
`include "bsr_regs.svh"
module bsr_reg_map
    import bsr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        por_event,
    input  wire logic        bor_event,
    input  wire logic        wdt_event,
    input  wire logic        core_sleep,
    input  wire logic        variant_28pin,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // core and peripheral state shown on reads
    input  wire logic [7:0]  pc_low_cur,
    input  wire logic        par_in_full,
    input  wire logic        par_out_full,
    input  wire logic        par_in_ovf_evt,
    input  wire logic [5:0]  ssp_state_in,
    input  wire logic        utx_shift_empty,
    input  wire logic [7:0]  adc_result_lo,
    // register contents towards the core and peripherals
    output logic [7:0]       timer_option,
    output logic [7:0]       core_status,
    output logic [7:0]       ind_pointer,
    output logic [5:0]       port_a_dir,
    output logic [7:0]       port_b_dir,
    output logic [7:0]       port_c_dir,
    output logic [7:0]       port_d_dir,
    output logic [7:0]       port_e_ctrl,
    output logic [4:0]       pc_high_latch,
    output logic [7:0]       int_ctrl,
    output logic [7:0]       pie_a,
    output logic [7:0]       pie_b,
    output logic [1:0]       reset_cause,
    output logic [7:0]       ssp_ctrl_b,
    output logic [7:0]       timer2_period,
    output logic [7:0]       ssp_slave_addr,
    output logic [1:0]       ssp_smp_cke,
    output logic [7:0]       utx_ctrl,
    output logic [7:0]       baud_div,
    output logic [7:0]       adc_cfg,
    output logic             pc_load,
    output logic [12:0]      pc_target,
    output logic             small_pkg
);

    // ****************************************************************
    // internal signals
    // ****************************************************************
    bsr_wr_if  wbus ();
    bsr_addr_t dir_addr;
    bsr_addr_t ind_addr;
    bsr_addr_t eff_addr;
    bsr_addr_t hit;
    logic      hit_ok;
    logic      is_ind;
    bsr_byte_t rd_val;
    logic      pready_q;
    logic [31:0] prdata_q;
    logic      pc_load_q;
    logic [12:0] pc_target_q;
    logic [7:0] status_q;
    logic [1:0] cause_q;
    logic [1:0] smp_cke_q;
    logic [7:0] utx_q;
    logic       ibov_q;
    logic [7:0] pe_q;
    logic       small_pkg_q;

    // ****************************************************************
    // reset sorting and shared write carrier
    // ****************************************************************
    bsr_rst_kind u_rst_kind
    (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .por_event     (por_event),
        .bor_event     (bor_event),
        .variant_28pin (variant_28pin),
        .bus           (wbus),
        .small_pkg_q   (small_pkg_q)
    );

    // a write lands only at the access edge where pready is seen high
    assign wbus.wr_go = psel && penable && pready_q && pwrite;
    assign wbus.wdata = pwdata[7:0];

    // ****************************************************************
    // address decode
    // ****************************************************************
    // mirrored core registers answer in every bank
    function automatic logic bsr_mirrored(input logic [6:0] a);
        bsr_mirrored = (a == 7'(`BSR_IDX_IND_DATA)) || (a == 7'(`BSR_IDX_PC_LOW))
                    || (a == 7'(`BSR_IDX_STATUS)) || (a == 7'(`BSR_IDX_IND_PTR))
                    || (a == 7'(`BSR_IDX_PC_HLATCH)) || (a == 7'(`BSR_IDX_INT_CTRL));
    endfunction

    // direct address takes its bank from the status bank bits
    assign dir_addr = {status_q[`BSR_ST_BANK_HI], status_q[`BSR_ST_BANK_LO], paddr[8:2]};
    assign ind_addr = {status_q[`BSR_ST_IRP], ind_pointer};
    assign is_ind   = (paddr[8:2] == 7'(`BSR_IDX_IND_DATA));
    assign eff_addr = is_ind ? ind_addr : dir_addr;

    // fold mirrors onto bank one, anything else must sit in bank one
    always_comb
    begin
        hit    = {`BSR_BANK_ONE, eff_addr[6:0]};
        hit_ok = 1'b0;
        if (bsr_mirrored(eff_addr[6:0]))
            hit_ok = 1'b1;
        else if (eff_addr[8:7] == `BSR_BANK_ONE)
            hit_ok = 1'b1;
        // indirect through itself reaches no physical register
        if (is_ind && (ind_addr[6:0] == 7'(`BSR_IDX_IND_DATA)))
            hit_ok = 1'b0;
    end

    // per-register write select, empty when the address misses
    function automatic logic bsr_sel(input bsr_addr_t idx, input bsr_addr_t h, input logic ok);
        bsr_sel = ok && (h == idx);
    endfunction

    // ****************************************************************
    // plain storage registers
    // ****************************************************************
    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ONES)) u_tmr_opt
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_TMR_OPT, hit, hit_ok)),
        .q       (timer_option)
    );

    // pointer keeps its value on other resets
    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ZERO), .KEEP(`BSR_KEEP_ALL)) u_ind_ptr
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_IND_PTR, hit, hit_ok)),
        .q       (ind_pointer)
    );

    // direction registers come up as inputs
    bsr_dreg #(.W(6), .PWR_VAL(`BSR_RST_PA_DIR)) u_pa_dir
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_PA_DIR, hit, hit_ok)),
        .q       (port_a_dir)
    );

    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ONES)) u_pb_dir
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_PB_DIR, hit, hit_ok)),
        .q       (port_b_dir)
    );

    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ONES)) u_pc_dir
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_PC_DIR, hit, hit_ok)),
        .q       (port_c_dir)
    );

    // absent on the small package, so writes are dropped there
    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ONES)) u_pd_dir
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_PD_DIR, hit, hit_ok) && !small_pkg_q),
        .q       (port_d_dir)
    );

    // five-bit buffer for pc bits 12:8, never the pc itself
    bsr_dreg #(.W(5), .PWR_VAL(`BSR_RST_ZERO)) u_pc_hlatch
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_PC_HLATCH, hit, hit_ok)),
        .q       (pc_high_latch)
    );

    // flag in bit 0 keeps its value on other resets
    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ZERO), .KEEP(`BSR_KEEP_INT_CTRL)) u_int_ctrl
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_INT_CTRL, hit, hit_ok)),
        .q       (int_ctrl)
    );

    // reserved bit 7 on the small package is still stored; software keeps it clear
    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ZERO)) u_pie_a
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_PIE_A, hit, hit_ok)),
        .q       (pie_a)
    );

    // only bits 6, 4, 3 and 0 exist; reserved bit 6 is left to software
    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ZERO), .MASK(`BSR_PIE_B_MASK)) u_pie_b
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_PIE_B, hit, hit_ok)),
        .q       (pie_b)
    );

    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ZERO)) u_ssp_ctrl_b
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_SSP_CTRL_B, hit, hit_ok)),
        .q       (ssp_ctrl_b)
    );

    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ONES)) u_tmr2_per
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_TMR2_PER, hit, hit_ok)),
        .q       (timer2_period)
    );

    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ZERO)) u_ssp_addr
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_SSP_ADDR, hit, hit_ok)),
        .q       (ssp_slave_addr)
    );

    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ZERO)) u_baud_div
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_BAUD_DIV, hit, hit_ok)),
        .q       (baud_div)
    );

    bsr_dreg #(.W(8), .PWR_VAL(`BSR_RST_ZERO), .MASK(`BSR_ADC_CFG_MASK)) u_adc_cfg
    (
        .clk_sys (clk_sys),
        .bus     (wbus),
        .sel     (bsr_sel(`BSR_IDX_ADC_CFG, hit, hit_ok)),
        .q       (adc_cfg)
    );

    // ****************************************************************
    // mixed-access registers
    // ****************************************************************
    // status: to/pd follow the reset cause, low flags kept on other resets
    always_ff @(posedge clk_sys)
    begin
        if (wbus.rst_pwr)
            status_q <= `BSR_RST_STATUS;
        else if (wbus.rst_oth)
            status_q <= {3'b000, !wdt_event, !core_sleep, status_q[2:0]};
        else if (wbus.wr_go && bsr_sel(`BSR_IDX_STATUS, hit, hit_ok))
            status_q <= (wbus.wdata & `BSR_ST_SW_MASK) | (status_q & ~`BSR_ST_SW_MASK);
    end

    // reset cause: power-on clears both, brown-out clears its own bit
    always_ff @(posedge clk_sys)
    begin
        if (wbus.rst_pwr)
        begin
            cause_q[1] <= por_event ? 1'b0 : cause_q[1];
            cause_q[0] <= 1'b0;
        end
        else if (wbus.wr_go && bsr_sel(`BSR_IDX_RST_CAUSE, hit, hit_ok))
            cause_q <= wbus.wdata[1:0];
    end

    // port e control, absent on the small package
    always_ff @(posedge clk_sys)
    begin
        if (wbus.rst_pwr || wbus.rst_oth)
            pe_q <= `BSR_RST_PE_CTRL;
        else if (wbus.wr_go && bsr_sel(`BSR_IDX_PE_CTRL, hit, hit_ok) && !small_pkg_q)
            pe_q <= wbus.wdata & `BSR_PE_DIR_MASK;
    end

    // overflow flag: set by the port, cleared by software; set wins
    always_ff @(posedge clk_sys)
    begin
        if (wbus.rst_pwr || wbus.rst_oth)
            ibov_q <= 1'b0;
        else if (par_in_ovf_evt)
            ibov_q <= 1'b1;
        else if (wbus.wr_go && bsr_sel(`BSR_IDX_PE_CTRL, hit, hit_ok) && !small_pkg_q)
            ibov_q <= wbus.wdata[5];
    end

    // serial state: only the two top bits are writable
    always_ff @(posedge clk_sys)
    begin
        if (wbus.rst_pwr || wbus.rst_oth)
            smp_cke_q <= 2'b00;
        else if (wbus.wr_go && bsr_sel(`BSR_IDX_SSP_STATE, hit, hit_ok))
            smp_cke_q <= wbus.wdata[7:6];
    end

    // transmit control; shift-empty bit comes live from the transmitter
    always_ff @(posedge clk_sys)
    begin
        if (wbus.rst_pwr || wbus.rst_oth)
            utx_q <= `BSR_RST_ZERO;
        else if (wbus.wr_go && bsr_sel(`BSR_IDX_UTX_CTRL, hit, hit_ok))
            utx_q <= wbus.wdata & `BSR_UTX_MASK;
    end

    // writing pc low loads the full pc from the latch in one step
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pc_load_q   <= 1'b0;
            pc_target_q <= 13'h0000;
        end
        else
        begin
            pc_load_q <= wbus.wr_go && bsr_sel(`BSR_IDX_PC_LOW, hit, hit_ok);
            if (wbus.wr_go && bsr_sel(`BSR_IDX_PC_LOW, hit, hit_ok))
                pc_target_q <= {pc_high_latch, wbus.wdata};
        end
    end

    // ****************************************************************
    // read multiplexer
    // ****************************************************************
    // absent and unimplemented locations fall through to zero
    always_comb
    begin
        rd_val = `BSR_RST_ZERO;
        if (hit_ok)
        begin
            case (hit)
                `BSR_IDX_TMR_OPT:    rd_val = timer_option;
                `BSR_IDX_PC_LOW:     rd_val = pc_low_cur;
                `BSR_IDX_STATUS:     rd_val = status_q;
                `BSR_IDX_IND_PTR:    rd_val = ind_pointer;
                `BSR_IDX_PA_DIR:     rd_val = {2'b00, port_a_dir};
                `BSR_IDX_PB_DIR:     rd_val = port_b_dir;
                `BSR_IDX_PC_DIR:     rd_val = port_c_dir;
                `BSR_IDX_PD_DIR:     rd_val = small_pkg_q ? `BSR_RST_ZERO : port_d_dir;
                `BSR_IDX_PE_CTRL:    rd_val = small_pkg_q ? `BSR_RST_ZERO : port_e_ctrl;
                `BSR_IDX_PC_HLATCH:  rd_val = {3'b000, pc_high_latch};
                `BSR_IDX_INT_CTRL:   rd_val = int_ctrl;
                `BSR_IDX_PIE_A:      rd_val = pie_a;
                `BSR_IDX_PIE_B:      rd_val = pie_b;
                `BSR_IDX_RST_CAUSE:  rd_val = {6'b00_0000, cause_q};
                `BSR_IDX_SSP_CTRL_B: rd_val = ssp_ctrl_b;
                `BSR_IDX_TMR2_PER:   rd_val = timer2_period;
                `BSR_IDX_SSP_ADDR:   rd_val = ssp_slave_addr;
                `BSR_IDX_SSP_STATE:  rd_val = {smp_cke_q, ssp_state_in};
                `BSR_IDX_UTX_CTRL:   rd_val = {utx_q[7:2], utx_shift_empty, utx_q[0]};
                `BSR_IDX_BAUD_DIV:   rd_val = baud_div;
                `BSR_IDX_ADC_RES_LO: rd_val = adc_result_lo;
                `BSR_IDX_ADC_CFG:    rd_val = adc_cfg;
                default:             rd_val = `BSR_RST_ZERO;
            endcase
        end
    end

    // ****************************************************************
    // apb handshake: no wait state, read data caught in setup
    // ****************************************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= psel && !penable && !pready_q;
            if (psel && !penable)
                prdata_q <= {24'h00_0000, rd_val};
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign port_e_ctrl = {par_in_full, par_out_full, ibov_q, pe_q[4], 1'b0, pe_q[2:0]};
    assign core_status = status_q;
    assign reset_cause = cause_q;
    assign ssp_smp_cke = smp_cke_q;
    assign utx_ctrl    = utx_q;
    assign pc_load     = pc_load_q;
    assign pc_target   = pc_target_q;
    assign small_pkg   = small_pkg_q;
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = 1'b0; // misses answer with zero data, never an error

endmodule // bsr_reg_map

// [logic/bsr_rst_kind.sv]
// sorts the synchronous reset into power-up and other, catches the variant strap
// assumes: cause inputs are valid while rst is high
`timescale 1ns/1ps
module bsr_rst_kind
    import bsr_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic por_event,
    input  wire logic bor_event,
    input  wire logic variant_28pin,
    bsr_wr_if.kind    bus,
    output logic      small_pkg_q
);
    bsr_rst_kind_t kind;

    // power-on or brown-out selects the first column
    always_comb
    begin
        kind = BSR_RST_NONE;
        if (rst)
            kind = (por_event || bor_event) ? BSR_RST_PWR : BSR_RST_OTHER;
    end

    assign bus.rst_pwr = (kind == BSR_RST_PWR);
    assign bus.rst_oth = (kind == BSR_RST_OTHER);

    // strap is sampled by a clocked process while reset is held
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            small_pkg_q <= variant_28pin;
    end
endmodule // bsr_rst_kind

// [verif/banked_special_register_map_test.sv]
// bench: apb tests of the bank-one register map
// assumes: package, interface, design and checker compiled first
`timescale 1ns/1ps
module banked_special_register_map_test;
    import bsr_pkg::*;
    // ****************************************************************
    // signals and instance
    // ****************************************************************
    logic        clk_sys = 0, rst = 1, por_event = 1, bor_event = 0, wdt_event = 0;
    logic        core_sleep = 0, variant_28pin = 0, psel = 0, penable = 0, pwrite = 0;
    logic        par_in_full = 0, par_out_full = 0, par_in_ovf_evt = 0, utx_shift_empty = 1;
    logic        pready, pslverr, pc_load, small_pkg;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [7:0]  pc_low_cur = 8'h5a, adc_result_lo = 8'h3c, timer_option, core_status;
    logic [7:0]  ind_pointer, port_b_dir, port_c_dir, port_d_dir, port_e_ctrl, int_ctrl;
    logic [7:0]  pie_a, pie_b, ssp_ctrl_b, timer2_period, ssp_slave_addr, utx_ctrl;
    logic [7:0]  baud_div, adc_cfg;
    logic [5:0]  ssp_state_in = 6'h15, port_a_dir;
    logic [4:0]  pc_high_latch;
    logic [1:0]  reset_cause, ssp_smp_cke;
    logic [12:0] pc_target;
    int          n_fail = 0, checked = 0;
    bsr_reg_map u_bsr_reg_map (.*);
    // free-running 25 MHz clock
    initial forever #20 clk_sys = ~clk_sys;
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // one transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [6:0] i, input logic [7:0] d,
                       output logic [31:0] r);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= {3'h0, i, 2'h0};
        pwdata <= {24'h00_0000, d};
        @(posedge clk_sys);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        r = prdata;
        psel <= 0;
        penable <= 0;
        if (n == 20)
        begin
            n_fail++;
            print_verdict();
        end
        else
            @(posedge clk_sys);
    endtask
    task automatic wr(input logic [6:0] i, input logic [7:0] d);
        logic [31:0] x;
        apb(1, i, d, x);
    endtask
    task automatic rd(input logic [6:0] i, input logic [7:0] e);
        logic [31:0] x;
        apb(0, i, 8'h00, x);
        check(x, {24'h00_0000, e});
    endtask
    // causes held with rst, dropped together with it
    task automatic do_rst(input logic p, input logic b, input logic w);
        rst <= 1;
        por_event <= p;
        bor_event <= b;
        wdt_event <= w;
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        por_event <= 0;
        bor_event <= 0;
        wdt_event <= 0;
        @(posedge clk_sys);
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        do_rst(1, 0, 0);
        rd(7'h03, 8'h18);
        rd(7'h05, 8'h00);
        wr(7'h03, 8'h20);
        rd(7'h03, 8'h38);
        rd(7'h05, 8'h3f);
        rd(7'h06, 8'hff);
        rd(7'h09, 8'h07);
        rd(7'h01, 8'hff);
        rd(7'h12, 8'hff);
        rd(7'h18, 8'h02);
        wr(7'h0f, 8'ha5);
        rd(7'h0f, 8'h00);
        wr(7'h0c, 8'h7f);
        rd(7'h0c, 8'h7f);
        wr(7'h0d, 8'h19);
        rd(7'h0d, 8'h19);
        $display("power-up and decode test done");
        wr(7'h0a, 8'hff);
        rd(7'h0a, 8'h1f);
        wr(7'h02, 8'h34);
        check({19'h0_0000, pc_target}, 32'h0000_1f34);
        rd(7'h02, 8'h5a);
        wr(7'h03, 8'h00);
        rd(7'h0a, 8'h1f);
        wr(7'h04, 8'h55);
        rd(7'h04, 8'h55);
        wr(7'h04, 8'h86);
        rd(7'h00, 8'hff);
        $display("pc and mirror test done");
        wr(7'h03, 8'h20);
        wr(7'h05, 8'h00);
        wr(7'h0e, 8'h03);
        do_rst(0, 0, 1);
        rd(7'h04, 8'h86);
        rd(7'h03, 8'h08);
        wr(7'h03, 8'h20);
        rd(7'h05, 8'h3f);
        rd(7'h0e, 8'h03);
        $display("other reset test done");
        variant_28pin <= 1;
        do_rst(0, 1, 0);
        wr(7'h03, 8'h20);
        wr(7'h08, 8'h00);
        check({24'h00_0000, port_d_dir}, 32'h0000_00ff);
        rd(7'h08, 8'h00);
        rd(7'h09, 8'h00);
        rd(7'h07, 8'hff);
        rd(7'h0e, 8'h02);
        $display("small package test done");
        print_verdict();
    end
endmodule // banked_special_register_map_test

// [verif/bsr_reg_map_chk.sv]
// checker: apb timing, reset columns and decode of the bank-one map
// assumes: bound into bsr_reg_map, one clock clk_sys, rst synchronous
`timescale 1ns/1ps
module bsr_reg_map_chk
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        por_event,
    input wire logic        bor_event,
    input wire logic        wdt_event,
    input wire logic        core_sleep,
    input wire logic        variant_28pin,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic [7:0]  core_status,
    input wire logic [5:0]  port_a_dir,
    input wire logic [7:0]  port_b_dir,
    input wire logic [7:0]  int_ctrl,
    input wire logic [4:0]  pc_high_latch,
    input wire logic        pc_load,
    input wire logic [12:0] pc_target,
    input wire logic        small_pkg
);
    // ****************************************************************
    // helpers
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic       setup;
    logic       wr_pc;
    logic       pwr;
    logic [7:0] wbyte;
    // single signals so that $past sees plain names
    assign setup = psel && !penable;
    assign wr_pc = psel && penable && pready && pwrite && paddr[8:2] == 7'h02;
    assign pwr   = por_event || bor_event;
    assign wbyte = pwdata[7:0];
    // answer comes one cycle after setup and lasts one cycle
    ready_after_setup_a: assert property (setup |=> pready) else $error("no pready");
    ready_single_a: assert property (pready |=> !pready) else $error("pready held");
    unmapped_zero_a: assert property (setup && paddr[8:2] == 7'h0f |=> prdata == '0)
        else $error("unmapped read not zero");
    bank_miss_a: assert property (setup && paddr[8:2] == 7'h05 && core_status[6:5] != 2'h1
        |=> prdata == '0) else $error("wrong bank answered");
    small_absent_a: assert property (setup && small_pkg && paddr[8:3] == 6'h04
        |=> prdata == '0) else $error("absent register answered");
    pc_load_a: assert property (wr_pc |=> pc_load
        && pc_target == {$past(pc_high_latch), $past(wbyte)}) else $error("pc transfer wrong");
    pc_quiet_a: assert property (pc_load |-> $past(wr_pc)) else $error("stray pc load");
    power_column_a: assert property ($fell(rst) && $past(pwr)
        |-> port_b_dir == 8'hff && port_a_dir == 6'h3f) else $error("power column wrong");
    other_column_a: assert property ($fell(rst) && !$past(pwr)
        |-> core_status[4:3] == {!$past(wdt_event), !$past(core_sleep)} && int_ctrl[7:1] == '0)
        else $error("other column wrong");
    variant_capture_a: assert property ($fell(rst) |-> small_pkg == $past(variant_28pin))
        else $error("strap not captured");
endmodule // bsr_reg_map_chk

bind bsr_reg_map bsr_reg_map_chk u_bsr_reg_map_chk (.*);
